// [inc/gbu_defines.vh]
/*
  Constants shared by the graphics blit instruction unit: command codes,
  operation and option field encodings, logic op selects and widths.
  Assumes it is included by bare name from the design files.
*/
`ifndef GBU_DEFINES_VH
`define GBU_DEFINES_VH

// ----------------------------------------------------------------
// Command codes presented on i_cmd
// ----------------------------------------------------------------
`define GBU_CMD_BLOCK 3'h0
`define GBU_CMD_WORD_OR 3'h1
`define GBU_CMD_EXT 3'h2
`define GBU_CMD_FILL 3'h3
`define GBU_CMD_RUN_LENGTH_BIT_TEST 3'h4

// ----------------------------------------------------------------
// Operation field and i field encodings
// ----------------------------------------------------------------
`define GBU_OP_AND 4'hA
`define GBU_OP_OR 4'h6
`define GBU_OP_XOR 4'hE
`define GBU_OP_FOR 4'hC
`define GBU_OP_STOD 4'h4
`define GBU_I_AND 2'h3
`define GBU_I_OTHER 2'h1

// ----------------------------------------------------------------
// Logic unit selects
// ----------------------------------------------------------------
`define GBU_LOP_AND 2'h0
`define GBU_LOP_OR 2'h1
`define GBU_LOP_XOR 2'h2
`define GBU_LOP_STOD 2'h3

// ----------------------------------------------------------------
// Widths and step sizes
// ----------------------------------------------------------------
`define GBU_WORD_BYTES 32'h00000002
`define GBU_ADDR_W 24
`define GBU_DATA_W 16

// ----------------------------------------------------------------
// External cycle kinds on o_ext_cycle
// ----------------------------------------------------------------
`define GBU_EXT_NONE 2'h0
`define GBU_EXT_SRC_RD 2'h1
`define GBU_EXT_DST_RD 2'h2
`define GBU_EXT_DST_WR 2'h3

`endif

// [verilog/gbu_logic_op.v]
/*
  Masked two-operand logic for one destination word.
  Assumes source already bit aligned; purely combinational.
*/
`timescale 1ns/1ps
`include "gbu_defines.vh"

module gbu_logic_op (
  // Operands
  input wire [15:0] i_src,
  input wire [15:0] i_dst,
  input wire [15:0] i_mask,
  // Operation select
  input wire [1:0] i_op,
  input wire i_inv,
  // Result
  output reg [15:0] o_res
);

  reg [15:0] src_eff;
  reg [15:0] func;

  // ----------------------------------------------------------------
  // Function then mask merge
  // ----------------------------------------------------------------
  always @* begin
    src_eff = i_inv ? ~i_src : i_src; // RQ2
    case (i_op)
      `GBU_LOP_AND: func = src_eff & i_dst;
      `GBU_LOP_OR: func = src_eff | i_dst;
      `GBU_LOP_XOR: func = src_eff ^ i_dst;
      default: func = src_eff;
    endcase
    o_res = (func & i_mask) | (i_dst & ~i_mask); // RQ22
  end

endmodule

// [verilog/gbu_core.v]
/*
  Execution unit for graphics instructions: masked block operations,
  word OR transfer, external-assist transfer, pattern fill and run-length
  bit test. Assumes register values are stable at i_start and a 16-bit
  byte-addressed memory bus that answers each request with one ack pulse.
*/
// Functional notes
// RQ1 - Block op takes bases, shift, height, masks, warps from r0-r7, width from stack.
// RQ2 - Five block ops: and, or, xor, store, each true/inverted; fast or true only.
// RQ3 - Decode 1010/11 and, 0110/01 or, 1110/01 xor.
// RQ4 - Decode 1100/01 fast or without options, 0100/01 store to destination.
// RQ5 - Format bits mark decreasing address, inverted source; extra bit only for and.
// RQ6 - Default increasing and true; each pair of choices mutually exclusive.
// RQ7 - Fast or rejects options and acts as increasing, true-source or.
// RQ8 - Edge masks apply per source word, not destination word.
// RQ9 - Horizontal direction from option; vertical from warp signs.
// RQ10 - Odd source warp accepted and handled correctly.
// RQ11 - Word or: shift source up by r2, or into dword, store, add two to r0, r1.
// RQ12 - External transfer loops source read, destination read, write over block.
// RQ13 - External transfer horizontal direction from sign of r4.
// RQ14 - External end: r0, r1 last plus warps; r4, r6, r7 kept.
// RQ15 - Lower flag zero adds source preload read per line; one omits it.
// RQ16 - Fill stores r3 at r0 r2 times, stepping by signed r1.
// RQ17 - Fill end: r1, r3 kept, r2 zero, r0 last written address.
// RQ18 - Bit test counts bits equal option upward from base plus offset, bounded.
// RQ19 - Bit test keeps r0, r3, r4; r1 new offset, r2 run length.
// RQ20 - General flag is last tested bit, or option if start at limit.
// RQ21 - Lower flag set on found or run at limit, else cleared.
// RQ22 - Destination bits under zero mask bits stay unchanged.
// RQ23 - Transfers use ordinary bus cycles, reads done first, wait states honoured.
`timescale 1ns/1ps
`include "gbu_defines.vh"

module gbu_core (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // Instruction issue
  input wire i_start,
  input wire [2:0] i_cmd,
  input wire [3:0] i_op_field,
  input wire [1:0] i_i_field,
  input wire i_fmt_dec,
  input wire i_fmt_inv,
  input wire i_fmt_x,
  input wire i_run_length_bit_test_opt,
  input wire i_fill_byte,
  input wire i_flag_l,
  // General registers and stack top
  input wire [31:0] i_r0,
  input wire [31:0] i_r1,
  input wire [31:0] i_r2,
  input wire [31:0] i_r3,
  input wire [31:0] i_r4,
  input wire [31:0] i_r5,
  input wire [31:0] i_r6,
  input wire [31:0] i_r7,
  input wire [31:0] i_width,
  // Results
  output wire o_busy,
  output reg o_done,
  output reg o_illegal,
  output wire [31:0] o_r0,
  output wire [31:0] o_r1,
  output wire [31:0] o_r2,
  output wire [31:0] o_r3,
  output wire [31:0] o_r5,
  output reg o_flag_f,
  output reg o_flag_l,
  output reg o_flag_wr,
  // Memory bus
  output reg o_bus_req,
  output reg o_bus_we,
  output reg [23:0] o_bus_addr,
  output reg [1:0] o_bus_be,
  output reg [15:0] o_bus_wdata,
  output reg [1:0] o_ext_cycle,
  input wire i_bus_ack,
  input wire [15:0] i_bus_rdata
);

  localparam [3:0] S_IDLE = 4'h0;
  localparam [3:0] S_SRD = 4'h1;
  localparam [3:0] S_DRD = 4'h2;
  localparam [3:0] S_DWR = 4'h3;
  localparam [3:0] S_PRE = 4'h4;
  localparam [3:0] S_DRD2 = 4'h5;
  localparam [3:0] S_DWR2 = 4'h6;
  localparam [3:0] S_FILL = 4'h7;
  localparam [3:0] S_TCHK = 4'h8;
  localparam [3:0] S_TBIT = 4'h9;

  reg [3:0] state_reg;
  reg [2:0] cmd_reg;
  reg [31:0] r0_reg, r1_reg, r2_reg, r3_reg, r4_reg, r5_reg, r6_reg, r7_reg;
  reg [31:0] hcnt_reg;
  reg [1:0] lop_reg;
  reg dec_reg, inv_reg, first_reg, half_reg, opt_reg, byte_reg, last_bit_reg, skip_reg;
  reg [15:0] lo_reg, prev_reg, srcw_reg, dlo_reg;

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function [31:0] f_step;
    input [31:0] a;
    input dec;
    begin
      f_step = dec ? a - `GBU_WORD_BYTES : a + `GBU_WORD_BYTES;
    end
  endfunction

  function [31:0] f_abs;
    input [31:0] v;
    begin
      f_abs = v[31] ? (~v + 32'h00000001) : v;
    end
  endfunction

  // ----------------------------------------------------------------
  // Block operation decode
  // ----------------------------------------------------------------
  wire is_and = (i_op_field == `GBU_OP_AND) && (i_i_field == `GBU_I_AND); // RQ3
  wire is_or = (i_op_field == `GBU_OP_OR) && (i_i_field == `GBU_I_OTHER); // RQ3
  wire is_xor = (i_op_field == `GBU_OP_XOR) && (i_i_field == `GBU_I_OTHER); // RQ3
  wire is_for = (i_op_field == `GBU_OP_FOR) && (i_i_field == `GBU_I_OTHER); // RQ4
  wire is_stod = (i_op_field == `GBU_OP_STOD) && (i_i_field == `GBU_I_OTHER); // RQ4
  wire dec_known = is_and | is_or | is_xor | is_for | is_stod;
  wire dec_ok = dec_known && (i_fmt_x == is_and) && !(is_for && (i_fmt_dec | i_fmt_inv)); // RQ5 RQ7
  wire [1:0] dec_lop = is_and ? `GBU_LOP_AND : is_xor ? `GBU_LOP_XOR :
                       is_stod ? `GBU_LOP_STOD : `GBU_LOP_OR;

  // ----------------------------------------------------------------
  // Datapath terms
  // ----------------------------------------------------------------
  wire [15:0] src_word = (half_reg) ? {i_bus_rdata[7:0], lo_reg[15:8]} : i_bus_rdata; // RQ10
  wire [31:0] pair_ia = {src_word, prev_reg} << r2_reg[3:0];
  wire [31:0] pair_da = {prev_reg, src_word} << r2_reg[3:0];
  wire [15:0] aligned = dec_reg ? pair_da[31:16] : pair_ia[31:16];
  wire last_word = (hcnt_reg == 32'h00000001);
  wire [15:0] mask = (first_reg ? r4_reg[15:0] : 16'hFFFF) & (last_word ? r5_reg[15:0] : 16'hFFFF); // RQ8
  wire [15:0] blk_res;
  wire [31:0] wor_res = {i_bus_rdata, dlo_reg} | ({16'h0000, srcw_reg} << r2_reg[3:0]); // RQ11
  wire [31:0] src_nx = f_step(r0_reg, dec_reg);
  wire [31:0] dst_nx = f_step(r1_reg, dec_reg);
  wire ext_line_end = (r5_reg <= f_abs(r4_reg));
  wire [31:0] t_baddr = r0_reg + {{3{r1_reg[31]}}, r1_reg[31:3]};
  wire [3:0] t_idx = {t_baddr[0], r1_reg[2:0]};
  wire t_bit = i_bus_rdata[t_idx];

  gbu_logic_op u_logic (
    .i_src(srcw_reg),
    .i_dst(i_bus_rdata),
    .i_mask(mask),
    .i_op(lop_reg),
    .i_inv(inv_reg),
    .o_res(blk_res)
  );

  assign o_busy = (state_reg != S_IDLE);
  assign o_r0 = r0_reg;
  assign o_r1 = r1_reg;
  assign o_r2 = r2_reg;
  assign o_r3 = r3_reg;
  assign o_r5 = r5_reg;

  // ----------------------------------------------------------------
  // Bus request issue
  // ----------------------------------------------------------------
  task t_issue;
    input [31:0] a;
    input we;
    input [1:0] be;
    input [15:0] d;
    input [1:0] kind;
    begin
      o_bus_req <= 1'b1;
      o_bus_addr <= a[23:0];
      o_bus_we <= we;
      o_bus_be <= be;
      o_bus_wdata <= d;
      o_ext_cycle <= kind;
    end
  endtask

  // Source read, split in two word reads when the address is odd
  task t_src;
    input [31:0] a;
    begin
      half_reg <= 1'b0;
      t_issue({a[31:1], 1'b0}, 1'b0, 2'h3, 16'h0000, `GBU_EXT_NONE); // RQ10
      state_reg <= S_SRD;
    end
  endtask

  task t_finish;
    begin
      o_done <= 1'b1;
      state_reg <= S_IDLE;
    end
  endtask

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      state_reg <= S_IDLE;
      cmd_reg <= `GBU_CMD_BLOCK;
      {r0_reg, r1_reg, r2_reg, r3_reg} <= {4{32'h00000000}};
      {r4_reg, r5_reg, r6_reg, r7_reg, hcnt_reg} <= {5{32'h00000000}};
      lop_reg <= `GBU_LOP_AND;
      {dec_reg, inv_reg, first_reg, half_reg, opt_reg, byte_reg, last_bit_reg, skip_reg} <= 8'h00;
      {lo_reg, prev_reg, srcw_reg, dlo_reg} <= {4{16'h0000}};
      {o_done, o_illegal, o_flag_f, o_flag_l, o_flag_wr, o_bus_req, o_bus_we} <= 7'h00;
      o_bus_addr <= 24'h000000;
      o_bus_be <= 2'h0;
      o_bus_wdata <= 16'h0000;
      o_ext_cycle <= `GBU_EXT_NONE;
    end else begin
      o_done <= 1'b0;
      o_illegal <= 1'b0;
      o_flag_wr <= 1'b0;
      if (i_bus_ack) begin
        o_bus_req <= 1'b0; // RQ23
      end
      case (state_reg)
        S_IDLE: begin
          if (i_start) begin
            cmd_reg <= i_cmd;
            {r0_reg, r1_reg, r2_reg, r3_reg} <= {i_r0, i_r1, i_r2, i_r3}; // RQ1
            {r4_reg, r5_reg, r6_reg, r7_reg} <= {i_r4, i_r5, i_r6, i_r7};
            hcnt_reg <= i_width; // RQ1
            lop_reg <= dec_lop;
            dec_reg <= i_fmt_dec & !is_for; // RQ6 RQ9
            inv_reg <= i_fmt_inv & !is_for; // RQ6
            first_reg <= 1'b1;
            prev_reg <= 16'h0000;
            opt_reg <= i_run_length_bit_test_opt;
            byte_reg <= i_fill_byte;
            skip_reg <= i_flag_l; // RQ15
            case (i_cmd)
              `GBU_CMD_BLOCK: begin
                if (!dec_ok) begin
                  o_illegal <= 1'b1; // RQ7
                  o_done <= 1'b1;
                end else if (i_width == 32'h00000000 || i_r3 == 32'h00000000) begin
                  o_done <= 1'b1;
                end else begin
                  t_src(i_r0);
                end
              end
              `GBU_CMD_WORD_OR: begin
                t_src(i_r0);
              end
              `GBU_CMD_EXT: begin
                r5_reg <= i_r2;
                if (i_r2 == 32'h00000000 || i_r3 == 32'h00000000) begin
                  o_done <= 1'b1;
                end else begin
                  t_issue(i_r0, 1'b0, 2'h3, 16'h0000, `GBU_EXT_SRC_RD); // RQ12
                  state_reg <= i_flag_l ? S_SRD : S_PRE; // RQ15
                end
              end
              `GBU_CMD_FILL: begin
                if (i_r2 == 32'h00000000) begin
                  o_done <= 1'b1;
                end else begin
                  t_issue(i_r0, 1'b1, i_fill_byte ? (i_r0[0] ? 2'h2 : 2'h1) : 2'h3,
                          i_fill_byte ? {2{i_r3[7:0]}} : i_r3[15:0], `GBU_EXT_NONE); // RQ16
                  state_reg <= S_FILL;
                end
              end
              `GBU_CMD_RUN_LENGTH_BIT_TEST: begin
                r2_reg <= 32'h00000000;
                state_reg <= S_TCHK;
              end
              default: begin
                o_illegal <= 1'b1;
                o_done <= 1'b1;
              end
            endcase
          end
        end
        S_PRE: begin
          if (i_bus_ack) begin
            t_issue(r0_reg, 1'b0, 2'h3, 16'h0000, `GBU_EXT_SRC_RD); // RQ15
            state_reg <= S_SRD;
          end
        end
        S_SRD: begin
          if (i_bus_ack) begin
            if (cmd_reg == `GBU_CMD_EXT) begin
              t_issue(r1_reg, 1'b0, 2'h3, 16'h0000, `GBU_EXT_DST_RD); // RQ12
              state_reg <= S_DRD;
            end else if (r0_reg[0] && !half_reg) begin
              lo_reg <= i_bus_rdata;
              half_reg <= 1'b1;
              t_issue({r0_reg[31:1], 1'b0} + `GBU_WORD_BYTES, 1'b0, 2'h3, 16'h0000, `GBU_EXT_NONE); // RQ10
            end else begin
              srcw_reg <= (cmd_reg == `GBU_CMD_BLOCK) ? aligned : src_word;
              prev_reg <= src_word;
              t_issue(r1_reg, 1'b0, 2'h3, 16'h0000, `GBU_EXT_NONE); // RQ23
              state_reg <= S_DRD;
            end
          end
        end
        S_DRD: begin
          if (i_bus_ack) begin
            if (cmd_reg == `GBU_CMD_WORD_OR) begin
              dlo_reg <= i_bus_rdata;
              t_issue(r1_reg + `GBU_WORD_BYTES, 1'b0, 2'h3, 16'h0000, `GBU_EXT_NONE);
              state_reg <= S_DRD2;
            end else if (cmd_reg == `GBU_CMD_EXT) begin
              t_issue(r1_reg, 1'b1, 2'h3, i_bus_rdata, `GBU_EXT_DST_WR); // RQ12
              state_reg <= S_DWR;
            end else begin
              t_issue(r1_reg, 1'b1, 2'h3, blk_res, `GBU_EXT_NONE); // RQ2 RQ22
              state_reg <= S_DWR;
            end
          end
        end
        S_DRD2: begin
          if (i_bus_ack) begin
            dlo_reg <= wor_res[31:16];
            t_issue(r1_reg, 1'b1, 2'h3, wor_res[15:0], `GBU_EXT_NONE); // RQ11
            state_reg <= S_DWR2;
          end
        end
        S_DWR2: begin
          if (i_bus_ack) begin
            t_issue(r1_reg + `GBU_WORD_BYTES, 1'b1, 2'h3, dlo_reg, `GBU_EXT_NONE);
            state_reg <= S_DWR;
          end
        end
        S_DWR: begin
          if (i_bus_ack) begin
            if (cmd_reg == `GBU_CMD_WORD_OR) begin
              r0_reg <= r0_reg + `GBU_WORD_BYTES; // RQ11
              r1_reg <= r1_reg + `GBU_WORD_BYTES;
              t_finish;
            end else if (cmd_reg == `GBU_CMD_EXT) begin
              if (!ext_line_end) begin
                r0_reg <= r0_reg + r4_reg; // RQ13
                r1_reg <= r1_reg + r4_reg;
                r5_reg <= r5_reg - f_abs(r4_reg);
                t_issue(r0_reg + r4_reg, 1'b0, 2'h3, 16'h0000, `GBU_EXT_SRC_RD);
                state_reg <= S_SRD;
              end else begin
                r0_reg <= r0_reg + r6_reg; // RQ14
                r1_reg <= r1_reg + r7_reg;
                r3_reg <= r3_reg - 32'h00000001;
                r5_reg <= r2_reg;
                if (r3_reg == 32'h00000001) begin
                  t_finish;
                end else begin
                  t_issue(r0_reg + r6_reg, 1'b0, 2'h3, 16'h0000, `GBU_EXT_SRC_RD);
                  state_reg <= skip_reg ? S_SRD : S_PRE; // RQ15
                end
              end
            end else begin
              first_reg <= 1'b0;
              if (!last_word) begin
                hcnt_reg <= hcnt_reg - 32'h00000001;
                r0_reg <= src_nx; // RQ9
                r1_reg <= dst_nx;
                t_src(src_nx);
              end else begin
                hcnt_reg <= i_width;
                first_reg <= 1'b1;
                prev_reg <= 16'h0000;
                r0_reg <= r0_reg + r6_reg; // RQ9
                r1_reg <= r1_reg + r7_reg;
                r3_reg <= r3_reg - 32'h00000001;
                if (r3_reg == 32'h00000001) begin
                  t_finish;
                end else begin
                  t_src(r0_reg + r6_reg);
                end
              end
            end
          end
        end
        S_FILL: begin
          if (i_bus_ack) begin
            r2_reg <= r2_reg - 32'h00000001; // RQ17
            if (r2_reg == 32'h00000001) begin
              t_finish;
            end else begin
              r0_reg <= r0_reg + r1_reg; // RQ16
              t_issue(r0_reg + r1_reg, 1'b1, byte_reg ? (r0_reg[0] ^ r1_reg[0] ? 2'h2 : 2'h1) : 2'h3,
                      byte_reg ? {2{r3_reg[7:0]}} : r3_reg[15:0], `GBU_EXT_NONE);
            end
          end
        end
        S_TCHK: begin
          if ($signed(r1_reg) >= $signed(r4_reg) || r2_reg == r3_reg) begin
            o_flag_f <= first_reg ? opt_reg : last_bit_reg; // RQ20
            o_flag_l <= (r2_reg == r3_reg); // RQ21
            o_flag_wr <= 1'b1;
            t_finish;
          end else begin
            t_issue({t_baddr[31:1], 1'b0}, 1'b0, 2'h3, 16'h0000, `GBU_EXT_NONE); // RQ18
            state_reg <= S_TBIT;
          end
        end
        S_TBIT: begin
          if (i_bus_ack) begin
            first_reg <= 1'b0;
            last_bit_reg <= t_bit;
            if (t_bit == opt_reg) begin
              r1_reg <= r1_reg + 32'h00000001; // RQ19
              r2_reg <= r2_reg + 32'h00000001;
              state_reg <= S_TCHK;
            end else begin
              o_flag_f <= t_bit; // RQ20
              o_flag_l <= 1'b1; // RQ21
              o_flag_wr <= 1'b1;
              t_finish;
            end
          end
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// [test/gbu_core_properties.sv]
/*
  Checker on the gbu_core ports: bus request hold, decode refusals, pulses.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "gbu_defines.vh"
module gbu_core_properties (
  // Clock and reset
  input wire i_clk_sys,
  input wire i_rst,
  // Issue
  input wire i_start,
  input wire [2:0] i_cmd,
  input wire [3:0] i_op_field,
  input wire [1:0] i_i_field,
  input wire i_fmt_dec,
  input wire i_fmt_inv,
  // Status
  input wire o_busy,
  input wire o_done,
  input wire o_illegal,
  input wire o_flag_wr,
  // Bus
  input wire o_bus_req,
  input wire o_bus_we,
  input wire [23:0] o_bus_addr,
  input wire [15:0] o_bus_wdata,
  input wire [1:0] o_ext_cycle,
  input wire i_bus_ack
);
  // ----------------
  // Properties
  // ----------------
  wire take = i_start && !o_busy;
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (i_rst);
  chk_req_hold: assert property (o_bus_req && !i_bus_ack |=> o_bus_req && $stable(o_bus_addr)
    && $stable(o_bus_we) && $stable(o_bus_wdata)) else $error("request moved before ack");
  chk_idle_quiet: assert property (!o_busy |-> !o_bus_req) else $error("request while idle");
  chk_fast_or_opts: assert property (take && i_cmd == `GBU_CMD_BLOCK && i_op_field == `GBU_OP_FOR
    && i_i_field == `GBU_I_OTHER && (i_fmt_dec || i_fmt_inv) |=> o_illegal) else $error("fast or options taken");
  chk_bad_cmd: assert property (take && i_cmd > `GBU_CMD_RUN_LENGTH_BIT_TEST |=> o_illegal && o_done)
    else $error("bad command accepted");
  chk_illegal_done: assert property (o_illegal |-> o_done && !o_busy) else $error("illegal without done");
  chk_done_pulse: assert property (o_done |=> !o_done || $past(take)) else $error("done not a pulse");
  chk_start_busy: assert property (take |=> o_busy || o_done) else $error("start not taken");
  chk_wr_kind: assert property (o_bus_req && o_ext_cycle == `GBU_EXT_DST_WR |-> o_bus_we)
    else $error("write cycle not a write");
  chk_rd_kind: assert property (o_bus_req && (o_ext_cycle == `GBU_EXT_SRC_RD || o_ext_cycle == `GBU_EXT_DST_RD)
    |-> !o_bus_we) else $error("read cycle is a write");
  chk_flag_wr: assert property (o_flag_wr |-> o_done && !o_illegal) else $error("flag write without done");
endmodule

bind gbu_core gbu_core_properties u_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_start(i_start),
  .i_cmd(i_cmd), .i_op_field(i_op_field), .i_i_field(i_i_field), .i_fmt_dec(i_fmt_dec),
  .i_fmt_inv(i_fmt_inv), .o_busy(o_busy), .o_done(o_done), .o_illegal(o_illegal), .o_flag_wr(o_flag_wr),
  .o_bus_req(o_bus_req), .o_bus_we(o_bus_we), .o_bus_addr(o_bus_addr), .o_bus_wdata(o_bus_wdata),
  .o_ext_cycle(o_ext_cycle), .i_bus_ack(i_bus_ack));

// [test/gbu_mem_model.sv]
/*
  Word memory on the core's bus with 0 to 2 wait cycles.
  Assumes byte addresses below 200h and one request at a time.
*/
`timescale 1ns/1ps
module gbu_mem_model (
  // Clock
  input wire i_clk_sys,
  // Request
  input wire i_req,
  input wire i_we,
  input wire [23:0] i_addr,
  input wire [1:0] i_be,
  input wire [15:0] i_wdata,
  input wire [1:0] i_wait,
  // Answer
  output reg o_ack,
  output reg [15:0] o_rdata
);
  reg [15:0] mem [0:255];
  reg [1:0] cnt_reg;
  wire [7:0] idx = i_addr[8:1];
  initial begin
    o_ack = 1'b0;
    o_rdata = 16'h0000;
    cnt_reg = 2'h0;
  end
  // Ack after the wait; read data toggles outside the ack cycle
  always @(posedge i_clk_sys) begin
    o_ack <= 1'b0;
    o_rdata <= ~o_rdata;
    if (i_req && !o_ack) begin
      if (cnt_reg >= i_wait) begin
        cnt_reg <= 2'h0;
        o_ack <= 1'b1;
        o_rdata <= mem[idx];
        if (i_we && i_be[0]) mem[idx][7:0] <= i_wdata[7:0];
        if (i_we && i_be[1]) mem[idx][15:8] <= i_wdata[15:8];
      end else begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end
endmodule

// [test/gbu_core_bench.sv]
/*
  Self-checking bench for gbu_core.
  Assumes the defines header and the memory model.
*/
`timescale 1ns/1ps
`include "gbu_defines.vh"
module gbu_core_bench;
  reg i_clk_sys, i_rst, i_start, i_fmt_dec, i_fmt_inv, i_fmt_x, i_run_length_bit_test_opt, i_flag_l, opt, inv, fnd;
  reg [2:0] i_cmd;
  reg [3:0] i_op_field;
  reg [1:0] i_i_field, wt;
  reg [31:0] r [0:7];
  reg [31:0] i_width, s, d, e, m, a;
  reg [23:0] wd;
  reg [3:0] opc [0:4];
  reg [23:0] wa [$];
  wire o_busy, o_done, o_illegal, o_flag_f, o_flag_l, o_flag_wr, o_bus_req, o_bus_we, i_bus_ack;
  wire [31:0] o_r0, o_r1, o_r2, o_r3, o_r5;
  wire [23:0] o_bus_addr;
  wire [15:0] o_bus_wdata, i_bus_rdata;
  wire [1:0] o_bus_be, o_ext_cycle;
  integer n_fail, tests_run, cyc, nbus, nsrc, j, k, n, p, mr, mo;
  // ----------------
  // Design and memory
  // ----------------
  gbu_core uut (.*, .i_fill_byte(1'b0), .i_r0(r[0]), .i_r1(r[1]), .i_r2(r[2]), .i_r3(r[3]), .i_r4(r[4]),
    .i_r5(r[5]), .i_r6(r[6]), .i_r7(r[7]));
  gbu_mem_model u_mem (.i_clk_sys(i_clk_sys), .i_req(o_bus_req), .i_we(o_bus_we), .i_addr(o_bus_addr),
    .i_be(o_bus_be), .i_wdata(o_bus_wdata), .i_wait(wt), .o_ack(i_bus_ack), .o_rdata(i_bus_rdata));
  // ----------------
  // Tasks
  // ----------------
  task chk(input [95:0] got, input [95:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks %0d fails %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
    end
  endtask
  task run(input [2:0] c);
    begin
      @(posedge i_clk_sys);
      i_cmd <= c;
      i_start <= 1'b1;
      wt <= $urandom % 3;
      @(posedge i_clk_sys);
      i_start <= 1'b0;
      #1;
      while (o_done !== 1'b1) begin
        @(posedge i_clk_sys);
        #1;
      end
      $display("cmd %0d done %0t", c, $time);
    end
  endtask
  function [15:0] exp_blk(input integer op, input v, input [15:0] sv, input [15:0] dv, input [15:0] mk);
    reg [15:0] x, f;
    begin
      x = v ? ~sv : sv;
      case (op)
        0: f = x & dv;
        2: f = x ^ dv;
        3: f = x;
        default: f = x | dv;
      endcase
      exp_blk = (f & mk) | (dv & ~mk);
    end
  endfunction
  // Clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end
  // Bus monitor and timeout
  always @(posedge i_clk_sys) begin
    cyc = cyc + 1;
    if (o_bus_req === 1'b1 && i_bus_ack === 1'b1) begin
      nbus = nbus + 1;
      if (o_ext_cycle == `GBU_EXT_SRC_RD) nsrc = nsrc + 1;
      if (o_ext_cycle == `GBU_EXT_DST_WR) wa.push_back(o_bus_addr);
    end
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  // ----------------
  // Main sequence
  // ----------------
  initial begin
    {i_rst, i_start, i_fmt_dec, i_fmt_inv, i_fmt_x, i_run_length_bit_test_opt, i_flag_l} = 7'h40;
    {i_cmd, i_op_field, i_i_field, wt, i_width} = 0;
    {n_fail, tests_run, cyc, nbus, nsrc} = 0;
    for (k = 0; k < 8; k = k + 1) r[k] = 32'h00000000;
    {opc[0], opc[1], opc[2], opc[3], opc[4]} = {`GBU_OP_AND, `GBU_OP_OR, `GBU_OP_XOR, `GBU_OP_STOD, `GBU_OP_FOR};
    k = $urandom(71618);
    for (k = 0; k < 256; k = k + 1) u_mem.mem[k] = $urandom;
    repeat (8) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    #1;
    chk(o_bus_req, 0);
    for (j = 0; j < 3; j = j + 1) begin
      @(posedge i_clk_sys);
      i_op_field <= (j == 1) ? `GBU_OP_OR : `GBU_OP_FOR;
      i_i_field <= `GBU_I_OTHER;
      i_fmt_dec <= (j == 0);
      i_fmt_x <= (j == 1);
      k = nbus;
      run((j == 2) ? 3'h5 : `GBU_CMD_BLOCK);
      chk(o_illegal, 1);
      chk(nbus, k);
    end
    for (j = 0; j < 5; j = j + 1) begin
      @(posedge i_clk_sys);
      inv = (j == 4) ? 1'b0 : $urandom;
      m = $urandom;
      i_op_field <= opc[j];
      i_i_field <= (j == 0) ? `GBU_I_AND : `GBU_I_OTHER;
      {i_fmt_x, i_fmt_dec, i_fmt_inv} <= {j == 0, 1'b0, inv};
      {r[0], r[1], r[2], r[3], r[4], r[5]} <= {32'h100 + m[16], 32'h140, 32'h0, 32'h1, m, m};
      {r[6], r[7], i_width} <= {32'h20, 32'h20, 32'h1};
      s = {u_mem.mem[8'h81], u_mem.mem[8'h80]} >> 8 * m[16];
      d = u_mem.mem[8'hA0];
      run(`GBU_CMD_BLOCK);
      chk(u_mem.mem[8'hA0], exp_blk(j, inv, s[15:0], d[15:0], m[15:0]));
      chk(o_r1, 32'h160);
    end
    @(posedge i_clk_sys);
    e = $urandom % 16;
    {r[0], r[1], r[2]} <= {32'h180, 32'h1A0, e};
    s = u_mem.mem[8'hC0];
    d = {u_mem.mem[8'hD1], u_mem.mem[8'hD0]};
    run(`GBU_CMD_WORD_OR);
    chk({u_mem.mem[8'hD1], u_mem.mem[8'hD0]}, d | (s << e[3:0]));
    chk(o_r0 + o_r1, 32'h324);
    @(posedge i_clk_sys);
    e = ($urandom % 2) ? 32'h4 : 32'hFFFFFFFC;
    m = $urandom;
    {r[0], r[1], r[2], r[3]} <= {32'h80, e, 32'h3, m};
    run(`GBU_CMD_FILL);
    for (k = 0; k < 3; k = k + 1) begin
      a = 32'h80 + k * e;
      chk(u_mem.mem[a[8:1]], m[15:0]);
    end
    chk(o_r0, a);
    chk({o_r1, o_r2, o_r3}, {e, 32'h0, m});
    for (j = 0; j < 6; j = j + 1) begin
      @(posedge i_clk_sys);
      opt = $urandom;
      p = $urandom % 24;
      mr = 1 + $urandom % 12;
      mo = (j == 0) ? p : $urandom % 40;
      i_run_length_bit_test_opt <= opt;
      {r[0], r[1], r[2], r[3], r[4]} <= {32'h1C0, p, 32'h0, mr, mo};
      n = 0;
      while (p < mo && n < mr && u_mem.mem[8'hE0 + p / 16][p % 16] == opt) begin
        n = n + 1;
        p = p + 1;
      end
      fnd = (p < mo && n < mr);
      run(`GBU_CMD_RUN_LENGTH_BIT_TEST);
      chk({o_r0, o_r1, o_r2}, {32'h1C0, p, n});
      chk(o_flag_f, fnd ^ opt);
      chk(o_flag_l, fnd || n == mr);
    end
    for (j = 0; j < 2; j = j + 1) begin
      @(posedge i_clk_sys);
      e = j ? 32'hFFFFFFFE : 32'h2;
      inv = $urandom;
      i_flag_l <= inv;
      {r[0], r[1], r[2], r[3], r[4], r[5]} <= {32'h20, j ? 32'h64 : 32'h60, 32'h4, 32'h2, e, 32'h0};
      {r[6], r[7]} <= {32'h10, 32'h10};
      nsrc = 0;
      wa.delete();
      run(`GBU_CMD_EXT);
      wd = wa[1] - wa[0];
      chk(nsrc, inv ? 4 : 6);
      chk(wa.size(), 4);
      chk(wd, e[23:0]);
    end
    tally_and_finish;
  end
endmodule
